//--- test/edu_link_sva.sv
// Checker for the four wires between the two link ends.
// Assumes a 100 MHz clock; mid- and slow-rate traffic avoids long high runs.
`timescale 1ns/1ns
`default_nettype none
module edu_link_sva (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic engine_txd,
  input wire logic datapath_txd,
  input wire logic engine_ready_n,
  input wire logic datapath_ready_n
);
  localparam int IDLE_MIN = 6336; // Over one fast frame
  localparam int LOW_MAX = 32000; // Ten slow bit periods
  logic [15:0] e_hi_q, d_hi_q, e_lo_q, d_lo_q;
  ////////////////////////////////////////////////////////////////////////////
  // Saturating run lengths of each line level
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      e_hi_q <= 16'h0;
      d_hi_q <= 16'h0;
      e_lo_q <= 16'h0;
      d_lo_q <= 16'h0;
    end else begin
      e_hi_q <= engine_txd ? e_hi_q + {15'h0, ~&e_hi_q} : 16'h0;
      d_hi_q <= datapath_txd ? d_hi_q + {15'h0, ~&d_hi_q} : 16'h0;
      e_lo_q <= engine_txd ? 16'h0 : e_lo_q + {15'h0, ~&e_lo_q};
      d_lo_q <= datapath_txd ? 16'h0 : d_lo_q + {15'h0, ~&d_lo_q};
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Wire rules
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  a_reset_idle_lines: assert property ($fell(RESET_I) |-> engine_txd && datapath_txd
    && !engine_ready_n && !datapath_ready_n) else $error("lines not idle after reset");
  a_eng_ready_stop: assert property ($rose(engine_ready_n) |-> datapath_txd
    && $past(datapath_txd)) else $error("engine ready rose outside stop bit");
  a_dp_ready_stop: assert property ($rose(datapath_ready_n) |-> engine_txd
    && $past(engine_txd)) else $error("data path ready rose outside stop bit");
  a_eng_low_bound: assert property (e_lo_q <= LOW_MAX)
    else $error("engine line low too long");
  a_dp_low_bound: assert property (d_lo_q <= LOW_MAX)
    else $error("data path line low too long");
  a_eng_start_gate: assert property ($fell(engine_txd) && e_hi_q >= IDLE_MIN
    |-> !$past(datapath_ready_n)) else $error("engine started while peer busy");
  a_dp_start_gate: assert property ($fell(datapath_txd) && d_hi_q >= IDLE_MIN
    |-> !$past(engine_ready_n)) else $error("data path started while peer busy");
  a_eng_start_bit: assert property ($fell(engine_txd) && e_hi_q >= IDLE_MIN
    |-> !engine_txd [*8]) else $error("start bit too short");
  c_eng_frame: cover property ($fell(engine_txd) && e_hi_q >= IDLE_MIN);
  c_dp_frame: cover property ($fell(datapath_txd) && d_hi_q >= IDLE_MIN);
  c_eng_full: cover property ($rose(engine_ready_n));
endmodule
`default_nettype wire

//--- test/tb_top.sv
// Bench joining both link ends, plus an engine end fed by a raw frame driver.
// Assumes the package and design files are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int B = 16 * edu_pkg::DIV_FAST_INT; // Fast bit in clocks
  logic       clk, rst, ack_v, ack_rdy, ack_busy, cmd_v, cmd_err, cmd_take;
  logic       dcmd_v, dcmd_rdy, dcmd_busy, dack_v, dack_err, dack_take;
  logic       e2_v, e2_err, e2_take;
  logic [1:0] rate;
  logic [7:0] ack_d, cmd_d, dcmd_d, dack_d, e2_d;
  int         error_cnt, checks, cyc_cnt;
  edu_link_if link ();
  edu_link_if link2 ();
  edu_engine_end edu_engine_end_inst (.CLK_I(clk), .RESET_I(rst), .RATE_I(rate), .link(link),
    .ACK_VALID_I(ack_v), .ACK_DATA_I(ack_d), .ACK_READY_O(ack_rdy), .ACK_BUSY_O(ack_busy),
    .CMD_VALID_O(cmd_v), .CMD_DATA_O(cmd_d), .CMD_ERR_O(cmd_err), .CMD_READY_I(cmd_take));
  edu_datapath_end edu_datapath_end_inst (.CLK_I(clk), .RESET_I(rst), .RATE_I(rate),
    .link(link), .CMD_VALID_I(dcmd_v), .CMD_DATA_I(dcmd_d), .CMD_READY_O(dcmd_rdy),
    .CMD_BUSY_O(dcmd_busy), .ACK_VALID_O(dack_v), .ACK_DATA_O(dack_d),
    .ACK_ERR_O(dack_err), .ACK_READY_I(dack_take));
  edu_engine_end edu_engine_end_inst2 (.CLK_I(clk), .RESET_I(rst), .RATE_I(rate),
    .link(link2), .ACK_VALID_I(1'b0), .ACK_DATA_I(8'h00), .ACK_READY_O(), .ACK_BUSY_O(),
    .CMD_VALID_O(e2_v), .CMD_DATA_O(e2_d), .CMD_ERR_O(e2_err), .CMD_READY_I(e2_take));
  edu_link_sva edu_link_sva_inst (.CLK_I(clk), .RESET_I(rst), .engine_txd(link.engine_txd),
    .datapath_txd(link.datapath_txd), .engine_ready_n(link.engine_ready_n),
    .datapath_ready_n(link.datapath_ready_n));
  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 99000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Both directions at once, every rate; wire bits checked at fast rate
  task automatic t_rates();
    logic [7:0] a, c;
    for (int r = 0; r < 3; r++) begin
      rate = r[1:0];
      a = (r == 0) ? 8'hab : 8'haa;
      c = (r == 0) ? 8'h4e : 8'h55;
      cyc(2);
      chk("ack_rdy", ack_rdy, 1'b1);
      {ack_v, ack_d, dcmd_v, dcmd_d} = {1'b1, a, 1'b1, c};
      cyc(1);
      {ack_v, dcmd_v} = 2'b00;
      chk("busy", {ack_busy, dcmd_busy, ack_rdy}, 3'h6);
      if (r == 0) begin
        cyc(B / 2 - 16);
        for (int k = 0; k < 11; k++) begin
          chk("engine_txd", link.engine_txd, {1'b1, ^a, a, 1'b0} >> k & 1);
          chk("datapath_txd", link.datapath_txd, {1'b1, ^c, c, 1'b0} >> k & 1);
          cyc(B);
        end
      end
      for (int n = 0; n < 40000 && {cmd_v, dack_v} !== 2'b11; n++) cyc(1);
      chk("rx", {cmd_v, dack_v, link.engine_ready_n, link.datapath_ready_n, cmd_err, dack_err},
        6'h3c);
      chk("cmd_d", cmd_d, c);
      chk("ack_d", dack_d, a);
      {cmd_take, dack_take} = 2'b11;
      cyc(1);
      {cmd_take, dack_take} = 2'b00;
      cyc(1);
      chk("ready_n", {link.engine_ready_n, link.datapath_ready_n}, 2'b00);
      for (int n = 0; n < 9000 && {ack_busy, dcmd_busy} !== 2'b00; n++) cyc(1);
      chk("idle", {ack_busy, dcmd_busy}, 2'h0);
    end
    $display("rates test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Full engine receiver holds off the data path sender
  task automatic t_flow();
    rate = 2'd0;
    {dcmd_v, dcmd_d} = {1'b1, 8'h11};
    cyc(1);
    dcmd_d = 8'h22;
    for (int n = 0; n < 9000 && cmd_v !== 1'b1; n++) cyc(1);
    cyc(7000);
    chk("refused", {dcmd_busy, dcmd_rdy, link.datapath_txd}, 3'b001);
    chk("held", {cmd_d, link.engine_ready_n}, {8'h11, 1'b1});
    cmd_take = 1'b1;
    cyc(1);
    cmd_take = 1'b0;
    cyc(2);
    chk("busy", dcmd_busy, 1'b1);
    dcmd_v = 1'b0;
    for (int n = 0; n < 9000 && cmd_v !== 1'b1; n++) cyc(1);
    chk("cmd_d", cmd_d, 8'h22);
    cmd_take = 1'b1;
    cyc(1);
    cmd_take = 1'b0;
    for (int n = 0; n < 9000 && dcmd_busy !== 1'b0; n++) cyc(1);
    $display("flow test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Raw frames: bad parity, low stop, then clean
  task automatic t_err();
    for (int j = 0; j < 3; j++) begin
      for (int k = 0; k < 11; k++) begin
        link2.datapath_txd = {j != 1, (^8'h5a) ^ (j == 0), 8'h5a, 1'b0} >> k & 1;
        cyc(B);
      end
      link2.datapath_txd = 1'b1;
      cyc(B);
      chk("err frame", {e2_v, e2_err, e2_d}, {1'b1, j != 2, 8'h5a});
      e2_take = 1'b1;
      cyc(1);
      e2_take = 1'b0;
    end
    $display("error test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst, rate, ack_v, ack_d, cmd_take, dcmd_v, dcmd_d, dack_take, e2_take} = {1'b1, 23'h0};
    {error_cnt, checks, cyc_cnt} = {32'h0, 32'h0, 32'h0};
    {link2.datapath_txd, link2.datapath_ready_n} = 2'b10;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    // Engine line idles through flow and error runs before its first frame
    t_flow();
    t_err();
    t_rates();
    end_of_test();
  end
endmodule
`default_nettype wire

//--- verilog/edu_datapath_end.sv
// Data path end of the serial link: sends commands, receives acknowledges.
// Assumes edu_serial_core compiled before this file.
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Data path end
module edu_datapath_end (
  input  wire logic       CLK_I,
  input  wire logic       RESET_I,
  input  wire logic [1:0] RATE_I,
  edu_link_if.datapath    link,
  input  wire logic       CMD_VALID_I,
  input  wire logic [7:0] CMD_DATA_I,
  output logic            CMD_READY_O,
  output logic            CMD_BUSY_O,
  output logic            ACK_VALID_O,
  output logic [7:0]      ACK_DATA_O,
  output logic            ACK_ERR_O,
  input  wire logic       ACK_READY_I
);
  // Transmit paced by engine ready, receive shows data path ready
  edu_serial_core #(
    .DATA_W (edu_pkg::DATA_BITS)
  ) u_core (
    .CLK_I          (CLK_I),
    .RESET_I        (RESET_I),
    .RATE_I         (RATE_I),
    .TX_LINE_O      (link.datapath_txd),
    .PEER_READY_N_I (link.engine_ready_n),
    .RX_LINE_I      (link.engine_txd),
    .OWN_READY_N_O  (link.datapath_ready_n),
    .TX_VALID_I     (CMD_VALID_I),
    .TX_DATA_I      (CMD_DATA_I),
    .TX_READY_O     (CMD_READY_O),
    .TX_BUSY_O      (CMD_BUSY_O),
    .RX_VALID_O     (ACK_VALID_O),
    .RX_DATA_O      (ACK_DATA_O),
    .RX_ERR_O       (ACK_ERR_O),
    .RX_READY_I     (ACK_READY_I)
  );
endmodule

`default_nettype wire

//--- verilog/edu_engine_end.sv
// Serial frame engine shared by both link ends, and the engine end itself.
// Assumes inputs synchronous to CLK_I and a peer using the same bit rate.
//
// Contract
// - Frame opens with low start bit, then byte
// - Even parity bit, then high stop bit
// - Eleven bit periods per frame, both paths
// - Send and receive paths run independently
// - Three selectable rates, same at both ends
// - Engine sends bytes paced by data path ready
// - Engine receives bytes, shows its own ready
// - Receiver times bits from each start edge
// - Data path ready low only when it accepts
// - Engine ready low only while receiver free
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Frame engine: one transmitter and one receiver on a shared tick
module edu_serial_core #(
  parameter int DATA_W = edu_pkg::DATA_BITS
) (
  input  wire logic              CLK_I,
  input  wire logic              RESET_I,
  input  wire logic [1:0]        RATE_I,
  output logic                   TX_LINE_O,
  input  wire logic              PEER_READY_N_I,
  input  wire logic              RX_LINE_I,
  output logic                   OWN_READY_N_O,
  input  wire logic              TX_VALID_I,
  input  wire logic [DATA_W-1:0] TX_DATA_I,
  output logic                   TX_READY_O,
  output logic                   TX_BUSY_O,
  output logic                   RX_VALID_O,
  output logic [DATA_W-1:0]      RX_DATA_O,
  output logic                   RX_ERR_O,
  input  wire logic              RX_READY_I
);
  localparam int FRAME_W = DATA_W + edu_pkg::OVERHEAD_BITS;
  localparam int SAMP_W  = DATA_W + 2;
  localparam logic [edu_pkg::BIT_W-1:0] TX_BIT_LAST = edu_pkg::BIT_W'(FRAME_W - 1);
  localparam logic [edu_pkg::BIT_W-1:0] RX_BIT_LAST = edu_pkg::BIT_W'(SAMP_W - 1);

  // Bit counters are four bits wide
  if (DATA_W < 1 || DATA_W > 12) begin : g_bad_width
    $error("edu_serial_core: DATA_W must be 1 to 12");
  end

  typedef struct packed {
    logic [edu_pkg::DIV_W-1:0] div;
    logic                      tick;
    logic                      tx_busy;
    logic [edu_pkg::OS_W-1:0]  tx_os;
    logic [edu_pkg::BIT_W-1:0] tx_bit;
    logic [FRAME_W-1:0]        tx_sh;
    edu_pkg::edu_rx_e          rx_st;
    logic [edu_pkg::OS_W-1:0]  rx_os;
    logic [edu_pkg::BIT_W-1:0] rx_bit;
    logic [SAMP_W-1:0]         rx_sh;
    logic                      rx_prev;
    logic                      rx_full;
    logic [DATA_W-1:0]         rx_data;
    logic                      rx_err;
  } edu_core_s;

  edu_core_s                 q;
  edu_core_s                 d;
  logic [edu_pkg::DIV_W-1:0] div_load;
  logic                      tx_take;

  //////////////////////////////////////////////////////////////////////////////
  // Rate select to tick divider reload
  always_comb begin
    case (edu_pkg::edu_rate_e'(RATE_I))
      edu_pkg::RATE_FAST: div_load = edu_pkg::DIV_FAST_LOAD;
      edu_pkg::RATE_MID:  div_load = edu_pkg::DIV_MID_LOAD;
      default:            div_load = edu_pkg::DIV_SLOW_LOAD;
    endcase
  end

  // Handshakes and line outputs
  assign TX_READY_O    = !q.tx_busy && !PEER_READY_N_I;
  assign tx_take       = TX_VALID_I && TX_READY_O;
  assign TX_BUSY_O     = q.tx_busy;
  assign TX_LINE_O     = q.tx_sh[0];
  assign OWN_READY_N_O = q.rx_full;
  assign RX_VALID_O    = q.rx_full;
  assign RX_DATA_O     = q.rx_data;
  assign RX_ERR_O      = q.rx_err;

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [SAMP_W-1:0] sh_new;
    sh_new = {RX_LINE_I, q.rx_sh[SAMP_W-1:1]};
    d      = q;

    // Oversampling tick, 16 per bit
    d.tick = 1'b0;
    if (q.div == '0) begin
      d.div  = div_load;
      d.tick = 1'b1;
    end else begin
      d.div = q.div - edu_pkg::DIV_W'(1);
    end

    // Transmitter: load start, data, parity, stop; shift LSB first
    if (tx_take) begin
      d.tx_busy = 1'b1;
      d.tx_os   = '0;
      d.tx_bit  = '0;
      d.tx_sh   = {1'b1, ^TX_DATA_I, TX_DATA_I, 1'b0};
    end else if (q.tx_busy && q.tick) begin
      d.tx_os = q.tx_os + edu_pkg::OS_W'(1);
      if (q.tx_os == edu_pkg::OS_LAST) begin
        d.tx_sh  = {1'b1, q.tx_sh[FRAME_W-1:1]};
        d.tx_bit = q.tx_bit + edu_pkg::BIT_W'(1);
        if (q.tx_bit == TX_BIT_LAST) begin
          d.tx_busy = 1'b0;
        end
      end
    end

    // Receive holding register: consumer clear first, new byte may set
    d.rx_prev = RX_LINE_I;
    if (RX_READY_I) begin
      d.rx_full = 1'b0;
    end

    // Receiver, independent of the transmitter
    case (q.rx_st)
      edu_pkg::RX_IDLE: begin
        if (q.rx_prev && !RX_LINE_I) begin
          d.rx_st = edu_pkg::RX_START;
          d.rx_os = '0;
        end
      end
      edu_pkg::RX_START: begin
        if (q.tick) begin
          d.rx_os = q.rx_os + edu_pkg::OS_W'(1);
          if (q.rx_os == edu_pkg::OS_MID) begin
            d.rx_os  = '0;
            d.rx_bit = '0;
            // False start returns to idle
            d.rx_st  = RX_LINE_I ? edu_pkg::RX_IDLE : edu_pkg::RX_BITS;
          end
        end
      end
      edu_pkg::RX_BITS: begin
        if (q.tick) begin
          d.rx_os = q.rx_os + edu_pkg::OS_W'(1);
          if (q.rx_os == edu_pkg::OS_LAST) begin
            d.rx_sh  = sh_new;
            d.rx_bit = q.rx_bit + edu_pkg::BIT_W'(1);
            if (q.rx_bit == RX_BIT_LAST) begin
              d.rx_st = edu_pkg::RX_IDLE;
              // Frame lost when the holding register is still full
              if (!d.rx_full) begin
                d.rx_full = 1'b1;
                d.rx_data = sh_new[DATA_W-1:0];
                d.rx_err  = (^sh_new[DATA_W:0]) | !sh_new[SAMP_W-1];
              end
            end
          end
        end
      end
      default: d.rx_st = edu_pkg::RX_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      q         <= '0;
      q.tx_sh   <= '1;
      q.rx_st   <= edu_pkg::RX_IDLE;
      q.rx_prev <= edu_pkg::LINE_IDLE;
    end else begin
      q <= d;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Engine end: sends acknowledges, receives commands
module edu_engine_end (
  input  wire logic       CLK_I,
  input  wire logic       RESET_I,
  input  wire logic [1:0] RATE_I,
  edu_link_if.engine      link,
  input  wire logic       ACK_VALID_I,
  input  wire logic [7:0] ACK_DATA_I,
  output logic            ACK_READY_O,
  output logic            ACK_BUSY_O,
  output logic            CMD_VALID_O,
  output logic [7:0]      CMD_DATA_O,
  output logic            CMD_ERR_O,
  input  wire logic       CMD_READY_I
);
  // Transmit paced by data path ready, receive shows engine ready
  edu_serial_core #(
    .DATA_W (edu_pkg::DATA_BITS)
  ) u_core (
    .CLK_I          (CLK_I),
    .RESET_I        (RESET_I),
    .RATE_I         (RATE_I),
    .TX_LINE_O      (link.engine_txd),
    .PEER_READY_N_I (link.datapath_ready_n),
    .RX_LINE_I      (link.datapath_txd),
    .OWN_READY_N_O  (link.engine_ready_n),
    .TX_VALID_I     (ACK_VALID_I),
    .TX_DATA_I      (ACK_DATA_I),
    .TX_READY_O     (ACK_READY_O),
    .TX_BUSY_O      (ACK_BUSY_O),
    .RX_VALID_O     (CMD_VALID_O),
    .RX_DATA_O      (CMD_DATA_O),
    .RX_ERR_O       (CMD_ERR_O),
    .RX_READY_I     (CMD_READY_I)
  );
endmodule

`default_nettype wire

//--- verilog/edu_link_if.sv
// Four-wire serial link between the engine end and the data path end.
// Assumes both ends run from the same clock rate and rate setting.
`timescale 1ns/1ns
`default_nettype none

interface edu_link_if;
  // Serial data, idle high
  logic engine_txd;
  logic datapath_txd;
  // Ready to take a frame, active low
  logic engine_ready_n;
  logic datapath_ready_n;

  modport engine (
    output engine_txd,
    output engine_ready_n,
    input  datapath_txd,
    input  datapath_ready_n
  );

  modport datapath (
    output datapath_txd,
    output datapath_ready_n,
    input  engine_txd,
    input  engine_ready_n
  );
endinterface

`default_nettype wire

//--- verilog/edu_pkg.sv
// Shared constants and types for the engine / data path serial link.
// Assumes a single 100 MHz system clock at both ends of the link.
package edu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and bit rates
  localparam int CLK_FREQ_HZ   = 100_000_000;
  localparam int RATE_FAST_BPS = 187_500;
  localparam int RATE_MID_BPS  = 62_500;
  localparam int RATE_SLOW_BPS = 31_250;
  localparam int OVERSAMPLE    = 16;

  // Clocks per oversampling tick, rounded down
  localparam int DIV_FAST_INT  = CLK_FREQ_HZ / (RATE_FAST_BPS * OVERSAMPLE);
  localparam int DIV_MID_INT   = CLK_FREQ_HZ / (RATE_MID_BPS * OVERSAMPLE);
  localparam int DIV_SLOW_INT  = CLK_FREQ_HZ / (RATE_SLOW_BPS * OVERSAMPLE);
  localparam int DIV_W         = 8;
  localparam logic [DIV_W-1:0] DIV_FAST_LOAD = DIV_W'(DIV_FAST_INT - 1);
  localparam logic [DIV_W-1:0] DIV_MID_LOAD  = DIV_W'(DIV_MID_INT - 1);
  localparam logic [DIV_W-1:0] DIV_SLOW_LOAD = DIV_W'(DIV_SLOW_INT - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Frame layout: start, data, parity, stop
  localparam int DATA_BITS     = 8;
  localparam int OVERHEAD_BITS = 3;
  localparam int FRAME_BITS    = DATA_BITS + OVERHEAD_BITS;
  localparam int OS_W          = 4;
  localparam int BIT_W         = 4;
  localparam logic [OS_W-1:0] OS_LAST = OS_W'(OVERSAMPLE - 1);
  localparam logic [OS_W-1:0] OS_MID  = OS_W'(OVERSAMPLE / 2 - 1);

  // Reset levels
  localparam logic LINE_IDLE = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    RATE_FAST,
    RATE_MID,
    RATE_SLOW
  } edu_rate_e;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_BITS
  } edu_rx_e;

endpackage
